// ===== dv/test_pws_seq.sv
`timescale 1ns/1ns
// self-checking bench for the power, sleep and boot sequencer
module test_pws_seq
  import pws_pkg::*;
;
  localparam int DIV = 4;
  localparam int XW = 8;
  localparam int SP = 16;
  localparam int LIMIT = 20000;
  // design inputs
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic vbus_gt_vbat_i = 1'b1;
  pws_reg_t reg_ok_i = '1;
  logic sleep_clk_i = 1'b0;
  logic wake_req_i = 1'b0;
  logic sleep_instruction_i = 1'b0;
  logic remap_nvm_i = 1'b1;
  logic [CNTDN_W-1:0] sleep_countdown_value_i = 16'h0003;
  logic ret_bat_en_i = 1'b1;
  logic ret_io_en_i = 1'b0;
  logic ret_io2_en_i = 1'b1;
  logic otp_valid_i = 1'b0;
  logic [OTP_W-1:0] otp_word_i = 64'h0123_4567_89ab_cdef;
  logic [SYN_W-1:0] otp_syndrome_i = 7'h00;
  logic otp_parity_err_i = 1'b0;
  logic [OTP_W-1:0] flag_word_i = 64'ha5a5_a5a5_a5a5_a5a5;
  logic trim_valid_i = 1'b0;
  logic trim_last_i = 1'b0;
  logic [OTP_W-1:0] trim_addr_word_i = 64'h0;
  logic [OTP_W-1:0] trim_data_word_i = 64'h0;
  logic boot_qspi_i = 1'b1;
  logic qspi_done_i = 1'b0;
  logic magic_valid_i = 1'b0;
  logic [15:0] magic_i = 16'h7151;
  // design outputs
  pws_reg_t reg_en_o;
  pws_clk_t clk_sel_o;
  pws_map_t addr0_map_o;
  logic fast_rc_en_o, fast_xtal_en_o, cpu_run_o, asleep_o, countdown_run_o;
  logic [OTP_W-1:0] otp_data_o;
  logic otp_corr_o, otp_dbl_err_o, trim_wr_o, trim_retry_o, hw_reset_o;
  logic [HALF_W-1:0] trim_addr_o, trim_data_o;
  logic xtal_use_o, boot_nvm_o, boot_serial_o, qspi_rst_o, qspi_init_o;
  logic image_ok_o, image_bad_o;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  logic wr, rt, f;
  logic [63:0] ga;

  pws_seq #(.SLOW_DIV(DIV), .XTAL_WAIT(XW)) i_pws_seq (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .vbus_gt_vbat_i(vbus_gt_vbat_i), .reg_ok_i(reg_ok_i),
    .sleep_clk_i(sleep_clk_i), .wake_req_i(wake_req_i),
    .sleep_instruction_i(sleep_instruction_i), .remap_nvm_i(remap_nvm_i),
    .sleep_countdown_value_i(sleep_countdown_value_i),
    .ret_bat_en_i(ret_bat_en_i), .ret_io_en_i(ret_io_en_i),
    .ret_io2_en_i(ret_io2_en_i), .otp_valid_i(otp_valid_i),
    .otp_word_i(otp_word_i), .otp_syndrome_i(otp_syndrome_i),
    .otp_parity_err_i(otp_parity_err_i), .flag_word_i(flag_word_i),
    .trim_valid_i(trim_valid_i), .trim_last_i(trim_last_i),
    .trim_addr_word_i(trim_addr_word_i),
    .trim_data_word_i(trim_data_word_i), .boot_qspi_i(boot_qspi_i),
    .qspi_done_i(qspi_done_i), .magic_valid_i(magic_valid_i),
    .magic_i(magic_i), .reg_en_o(reg_en_o), .fast_rc_en_o(fast_rc_en_o),
    .fast_xtal_en_o(fast_xtal_en_o), .clk_sel_o(clk_sel_o),
    .cpu_run_o(cpu_run_o), .addr0_map_o(addr0_map_o), .asleep_o(asleep_o),
    .countdown_run_o(countdown_run_o), .otp_data_o(otp_data_o),
    .otp_corr_o(otp_corr_o), .otp_dbl_err_o(otp_dbl_err_o),
    .trim_wr_o(trim_wr_o), .trim_addr_o(trim_addr_o),
    .trim_data_o(trim_data_o), .trim_retry_o(trim_retry_o),
    .hw_reset_o(hw_reset_o), .xtal_use_o(xtal_use_o),
    .boot_nvm_o(boot_nvm_o), .boot_serial_o(boot_serial_o),
    .qspi_rst_o(qspi_rst_o), .qspi_init_o(qspi_init_o),
    .image_ok_o(image_ok_o), .image_bad_o(image_bad_o)
  );

  // 250 MHz system clock
  initial
  begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // sleep clock at one sixteenth of the system clock, and a hang limit
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc % 8 == 7)
      sleep_clk_i <= #1 ~sleep_clk_i;
    if (cyc == LIMIT)
    begin
      miscompares++;
      end_of_test;
    end
  end

  task tick;
    @(posedge clk_sys_i);
    #1;
  endtask : tick

  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: %s", $time, m);
      miscompares++;
    end
  endtask : chk

  // wait for the cpu release level, bounded
  task wait_run(input logic want, output int k);
    k = 0;
    while (cpu_run_o !== want && k < 3000)
    begin
      tick;
      k++;
    end
  endtask : wait_run

  // one trim entry, bad means the inverse half is wrong
  task trim_send(input logic [31:0] a, input logic bad, input logic last);
    trim_addr_word_i = {(bad ? a : ~a), a};
    trim_data_word_i = {~(a ^ 32'h5a5a_0f0f), a ^ 32'h5a5a_0f0f};
    trim_valid_i = 1'b1;
    trim_last_i = last;
    tick;
    trim_valid_i = 1'b0;
    trim_last_i = 1'b0;
    wr = 1'b0;
    rt = 1'b0;
    repeat (4)
    begin
      if (trim_wr_o === 1'b1)
      begin
        wr = 1'b1;
        ga = {trim_addr_o, trim_data_o};
      end
      if (trim_retry_o === 1'b1)
        rt = 1'b1;
      tick;
    end
  endtask : trim_send

  // one otp word through the error correction
  task ecc_try(input logic [6:0] syn, input logic par, output logic [63:0] d);
    otp_syndrome_i = syn;
    otp_parity_err_i = par;
    otp_valid_i = 1'b1;
    tick;
    otp_valid_i = 1'b0;
    wr = 1'b0;
    rt = 1'b0;
    repeat (3)
    begin
      if (otp_corr_o === 1'b1)
      begin
        wr = 1'b1;
        d = otp_data_o;
      end
      if (otp_dbl_err_o === 1'b1)
        rt = 1'b1;
      tick;
    end
  endtask : ecc_try

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // power-up from usb, then the boot flow to a qspi image
  task t_powerup_usb;
    logic [63:0] d;
    chk(reg_en_o, 0, "regulators on in reset");
    chk(cpu_run_o, 0, "cpu runs in reset");
    chk(clk_sel_o, CLK_SLOW_RC, "reset clock");
    resetn_i = 1'b1;
    wait_run(1'b1, n);
    chk(n >= 15 * DIV && n <= 17 * DIV, 1, "power-up length");
    chk(reg_en_o.usb, 1, "usb regulator");
    chk(reg_en_o.bat, 0, "battery regulator with usb");
    chk(reg_en_o.bandgap, 1, "bandgap");
    chk({reg_en_o.io, reg_en_o.io2, reg_en_o.core}, 3'h7, "rails");
    chk({fast_rc_en_o, fast_xtal_en_o}, 2'h3, "fast oscillators");
    chk(clk_sel_o, CLK_FAST_RC, "fast clock");
    chk(addr0_map_o, MAP_ROM, "rom at zero");
    repeat (2) tick;
    trim_send(32'h5000_0010, 1'b0, 1'b0);
    chk(wr, 1, "trim write");
    chk(ga, {32'h5000_0010, 32'h0a5a_0f1f}, "trim words");
    trim_send(32'h5000_0014, 1'b1, 1'b0);
    chk({wr, rt}, 2'h1, "trim retry");
    trim_send(32'h5000_0014, 1'b0, 1'b1);
    chk(wr, 1, "trim write after retry");
    chk(xtal_use_o, 0, "crystal too early");
    repeat (XW + 3) tick;
    chk(xtal_use_o, 1, "crystal after wait");
    chk({boot_nvm_o, boot_serial_o}, 2'h2,
      "nvm path");
    chk(qspi_rst_o, 1, "qspi reset phase");
    qspi_done_i = 1'b1;
    tick;
    qspi_done_i = 1'b0;
    repeat (2) tick;
    chk(qspi_init_o, 1, "qspi init phase");
    qspi_done_i = 1'b1;
    tick;
    qspi_done_i = 1'b0;
    repeat (2) tick;
    magic_valid_i = 1'b1;
    tick;
    magic_valid_i = 1'b0;
    repeat (2) tick;
    chk({image_ok_o, image_bad_o}, 2'h2, "magic word");
    ecc_try(7'h05, 1'b1, d);
    chk(wr, 1, "single error flag");
    chk(d, otp_word_i ^ 64'h10, "single error");
    ecc_try(7'h03, 1'b0, d);
    chk(rt, 1, "double error");
  endtask : t_powerup_usb

  // sleep entry with retention, countdown wake to nvm
  task t_sleep_wake;
    sleep_instruction_i = 1'b1;
    tick;
    sleep_instruction_i = 1'b0;
    f = 1'b0;
    repeat (3)
    begin
      if (cpu_run_o === 1'b0 && clk_sel_o === CLK_FAST_RC)
        f = 1'b1;
      tick;
    end
    chk(f, 1, "fast clock on sleep request");
    repeat (3) tick;
    chk(asleep_o, 1, "asleep");
    chk(clk_sel_o, CLK_LOW_POWER, "low power clock");
    chk({reg_en_o.bat_ret, reg_en_o.io_ret, reg_en_o.io2_ret}, 3'h5,
      "retention");
    chk(reg_en_o.core, 0, "core off");
    chk({reg_en_o.usb, reg_en_o.bat, reg_en_o.io, reg_en_o.io2}, 0,
      "supplies off");
    chk(countdown_run_o, 1, "countdown runs");
    n = 0;
    while (asleep_o === 1'b1 && n < 10 * SP)
    begin
      tick;
      n++;
    end
    chk(n >= 2 * SP && n < 10 * SP, 1, "countdown wake");
    wait_run(1'b1, n);
    chk(n >= 10 * SP && n <= 17 * SP, 1, "wake length");
    chk(addr0_map_o, MAP_NVM, "nvm at zero on wake");
    chk(reg_en_o.bat_ret, 0, "retention cleared");
  endtask : t_sleep_wake

  // battery power-up held on an unsettled core, then trim failure
  task t_battery_trim_fail;
    resetn_i = 1'b0;
    repeat (6) tick;
    vbus_gt_vbat_i = 1'b0;
    reg_ok_i.core = 1'b0;
    resetn_i = 1'b1;
    // short stall, so the release still lands on the sixteenth tick
    repeat (8 * DIV) tick;
    chk(cpu_run_o, 0, "cpu held");
    chk(fast_rc_en_o, 0, "held at the core step");
    chk({reg_en_o.usb, reg_en_o.bat, reg_en_o.core}, 3'h3,
      "battery path");
    reg_ok_i.core = 1'b1;
    wait_run(1'b1, n);
    chk(cpu_run_o, 1, "cpu released");
    repeat (2) tick;
    repeat (4) trim_send(32'h5000_0020, 1'b1, 1'b0);
    chk(hw_reset_o, 0, "reset after four failures");
    trim_send(32'h5000_0020, 1'b1, 1'b0);
    chk(hw_reset_o, 1, "reset after five failures");
  endtask : t_battery_trim_fail

  // serial boot on a broken flag, then a pin wake into ram
  task t_serial_ram;
    resetn_i = 1'b0;
    repeat (6) tick;
    flag_word_i = 64'ha5a5_a5a5_a5a5_a4a5;
    remap_nvm_i = 1'b0;
    sleep_countdown_value_i = 16'h0000;
    resetn_i = 1'b1;
    wait_run(1'b1, n);
    chk(n >= 15 * DIV && n <= 17 * DIV, 1, "power-up length");
    repeat (2) tick;
    trim_send(32'h5000_0030, 1'b0, 1'b1);
    repeat (XW + 3) tick;
    chk({boot_nvm_o, boot_serial_o, qspi_rst_o}, 3'h2,
      "serial path");
    sleep_instruction_i = 1'b1;
    tick;
    sleep_instruction_i = 1'b0;
    repeat (3 * SP) tick;
    chk({asleep_o, countdown_run_o}, 2'h2, "no countdown");
    wake_req_i = 1'b1;
    wait_run(1'b1, n);
    wake_req_i = 1'b0;
    chk(n >= 10 * SP && n <= 17 * SP, 1, "pin wake length");
    chk(addr0_map_o, MAP_RAM, "ram at zero on wake");
  endtask : t_serial_ram

  initial
  begin
    repeat (6) tick;
    t_powerup_usb;
    t_sleep_wake;
    t_battery_trim_fail;
    t_serial_ram;
    end_of_test;
  end
endmodule : test_pws_seq

// ===== rtl/pws_pkg.sv
package pws_pkg;
  // clock rates and derived dividers
  localparam int SYS_CLK_HZ = 250_000_000;
  localparam int SLOW_RC_HZ = 32_000;
  localparam int SLOW_DIV_CYC = SYS_CLK_HZ / SLOW_RC_HZ;
  // sequence lengths in slow ticks, and the tick counter width
  localparam int SEQ_PWR_TICKS = 16;
  localparam int SEQ_WAKE_MIN = 11;
  localparam int SEQ_WAKE_MAX = 16;
  localparam int SEQ_CNT_W = 5;
  // boot flow figures
  localparam int TRIM_TRIES = 5;
  localparam int XTAL_WAIT_US = 200;
  localparam int XTAL_WAIT_CYC = XTAL_WAIT_US * (SYS_CLK_HZ / 1_000_000);
  localparam logic [15:0] QSPI_MAGIC = 16'h7151;
  localparam int OTP_W = 64;
  localparam int HALF_W = 32;
  localparam int SYN_W = 7;
  localparam int CNTDN_W = 16;

  typedef enum logic [1:0] {MAP_ROM, MAP_RAM, MAP_NVM} pws_map_t;
  typedef enum logic [1:0] {CLK_SLOW_RC, CLK_FAST_RC, CLK_LOW_POWER} pws_clk_t;

  // one bit per regulator, used for enables and settled indications
  typedef struct packed {
    logic usb;
    logic bat;
    logic bandgap;
    logic io;
    logic io2;
    logic core;
    logic bat_ret;
    logic io_ret;
    logic io2_ret;
  } pws_reg_t;
endpackage : pws_pkg

// ===== rtl/pws_seq.sv
`timescale 1ns/1ns
// Summary of operation
// (R1) run from slow RC clock after reset
// (R2) first sample usb-versus-battery comparison
// (R3) usb present: start usb regulator, then bandgap
// (R4) no usb: battery regulator, then bandgap
// (R5) io rails, then core regulator
// (R6) core up: start fast oscillators, fast clock
// (R7) sequence done: release cpu
// (R8) rom after power-up, ram/nvm after wake
// (R9) power-up finishes in 16 slow ticks
// (R10) wake on sleep clock, 11 to 16 ticks
// (R11) sleep request: fast rc clock, sleep machine
// (R12) low power clock, optional retention regulators
// (R13) sleep entry turns core regulator off
// (R14) then battery and io regulators off
// (R15) last state starts nonzero countdown, sleeps
// (R16) ecc corrects single, flags double errors
// (R17) flag accepted only if all bytes agree
// (R18) trim inverses checked before register write
// (R19) trim retry, hardware reset after 5 failures
// (R20) wait 200 us before crystal use
// (R21) production flag picks nvm or serial boot
// (R22) qspi: reset, init, check magic word
// (R23) advance only on settled, cpu held till end
module pws_seq
  import pws_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_DIV_CYC,
  parameter int XTAL_WAIT = XTAL_WAIT_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // analog status pins
  input wire logic vbus_gt_vbat_i,
  input wire pws_reg_t reg_ok_i,
  input wire logic sleep_clk_i,
  input wire logic wake_req_i,
  // cpu side control
  input wire logic sleep_instruction_i,
  input wire logic remap_nvm_i,
  input wire logic [CNTDN_W-1:0] sleep_countdown_value_i,
  input wire logic ret_bat_en_i,
  input wire logic ret_io_en_i,
  input wire logic ret_io2_en_i,
  // otp read port
  input wire logic otp_valid_i,
  input wire logic [OTP_W-1:0] otp_word_i,
  input wire logic [SYN_W-1:0] otp_syndrome_i,
  input wire logic otp_parity_err_i,
  input wire logic [OTP_W-1:0] flag_word_i,
  // trim_section copy
  input wire logic trim_valid_i,
  input wire logic trim_last_i,
  input wire logic [OTP_W-1:0] trim_addr_word_i,
  input wire logic [OTP_W-1:0] trim_data_word_i,
  // qspi boot
  input wire logic boot_qspi_i,
  input wire logic qspi_done_i,
  input wire logic magic_valid_i,
  input wire logic [15:0] magic_i,
  // power outputs
  output pws_reg_t reg_en_o,
  output logic fast_rc_en_o,
  output logic fast_xtal_en_o,
  output pws_clk_t clk_sel_o,
  output logic cpu_run_o,
  output pws_map_t addr0_map_o,
  output logic asleep_o,
  output logic countdown_run_o,
  // otp outputs
  output logic [OTP_W-1:0] otp_data_o,
  output logic otp_corr_o,
  output logic otp_dbl_err_o,
  // boot outputs
  output logic trim_wr_o,
  output logic [HALF_W-1:0] trim_addr_o,
  output logic [HALF_W-1:0] trim_data_o,
  output logic trim_retry_o,
  output logic hw_reset_o,
  output logic xtal_use_o,
  output logic boot_nvm_o,
  output logic boot_serial_o,
  output logic qspi_rst_o,
  output logic qspi_init_o,
  output logic image_ok_o,
  output logic image_bad_o
);
  typedef enum logic [3:0] {P_CMP, P_USB, P_BAT, P_BG, P_IO, P_CORE, P_HOLD,
    P_RUN, G_LPCLK, G_OFF, G_SLEEP} pws_pstate_t;
  typedef enum logic [2:0] {B_IDLE, B_TRIM, B_XWAIT, B_PATH, B_QRST, B_QINIT,
    B_QMAGIC, B_DONE} pws_bstate_t;

  // two-flop synchronisers for pins, third flop for sleep clock edge
  logic [11:0] sync1;
  logic [11:0] sync2;
  logic slk3;
  always_ff @(posedge clk_sys_i)
  begin
    sync1 <= {vbus_gt_vbat_i, reg_ok_i, sleep_clk_i, wake_req_i};
    sync2 <= sync1;
    slk3 <= sync2[1];
  end
  logic vbus_s;
  pws_reg_t ok_s;
  logic slk_s;
  logic wake_s;
  assign {vbus_s, ok_s, slk_s, wake_s} = sync2;

  // slow rc tick divider
  logic [15:0] div;
  logic rc_tick;
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      div <= '0;
    else
      div <= rc_tick ? '0 : div + 16'h0001;
  end
  assign rc_tick = (div == 16'(SLOW_DIV - 1));

  // power sequencer state
  pws_pstate_t ps, next_ps;
  logic waking, next_waking;
  logic [SEQ_CNT_W-1:0] cnt, next_cnt;
  logic [CNTDN_W-1:0] cdn, next_cdn;
  pws_reg_t next_reg_en;
  logic next_rc_en, next_xtal_en, next_cpu_run, next_asleep, next_cdn_run;
  pws_clk_t next_clk;
  pws_map_t next_map;
  logic tick;

  // wake runs on the sleep clock, power-up on slow rc
  assign tick = waking ? (slk_s & ~slk3) : rc_tick; // see (R1) see (R10)

  always_comb
  begin
    next_ps = ps;
    next_waking = waking;
    next_cnt = cnt;
    next_cdn = cdn;
    next_reg_en = reg_en_o;
    next_rc_en = fast_rc_en_o;
    next_xtal_en = fast_xtal_en_o;
    next_clk = clk_sel_o;
    next_cpu_run = cpu_run_o;
    next_map = addr0_map_o;
    next_asleep = asleep_o;
    next_cdn_run = countdown_run_o;
    if (tick && ps < P_RUN && cnt != '1)
      next_cnt = cnt + 1'b1;
    case (ps)
      P_CMP:
        if (tick)
        begin
          next_ps = vbus_s ? P_USB : P_BAT; // see (R2)
          next_reg_en.usb = vbus_s; // see (R3)
          next_reg_en.bat = ~vbus_s; // see (R4)
        end
      P_USB:
        if (tick && ok_s.usb) // see (R23)
        begin
          next_reg_en.bandgap = 1'b1; // see (R3)
          next_ps = P_BG;
        end
      P_BAT:
        if (tick && ok_s.bat) // see (R23)
        begin
          next_reg_en.bandgap = 1'b1; // see (R4)
          next_ps = P_BG;
        end
      P_BG:
        if (tick && ok_s.bandgap)
        begin
          next_reg_en.io = 1'b1; // see (R5)
          next_reg_en.io2 = 1'b1;
          next_ps = P_IO;
        end
      P_IO:
        if (tick && ok_s.io && ok_s.io2) // see (R23)
        begin
          next_reg_en.core = 1'b1; // see (R5)
          next_ps = P_CORE;
        end
      P_CORE:
        if (tick && ok_s.core)
        begin
          next_rc_en = 1'b1; // see (R6)
          next_xtal_en = 1'b1;
          next_clk = CLK_FAST_RC;
          next_ps = P_HOLD;
        end
      P_HOLD:
        // fixed length after power-up, shorter floor after wake
        if (cnt >= (waking ? SEQ_CNT_W'(SEQ_WAKE_MIN)
                           : SEQ_CNT_W'(SEQ_PWR_TICKS))) // see (R9) see (R10)
        begin
          next_cpu_run = 1'b1; // see (R7) see (R23)
          next_map = waking ? (remap_nvm_i ? MAP_NVM : MAP_RAM) : MAP_ROM; // see (R8)
          next_reg_en.bat_ret = 1'b0;
          next_reg_en.io_ret = 1'b0;
          next_reg_en.io2_ret = 1'b0;
          next_ps = P_RUN;
        end
      P_RUN:
        if (sleep_instruction_i)
        begin
          next_cpu_run = 1'b0;
          next_clk = CLK_FAST_RC; // see (R11)
          next_ps = G_LPCLK;
        end
      G_LPCLK:
      begin
        next_clk = CLK_LOW_POWER; // see (R12)
        next_reg_en.bat_ret = ret_bat_en_i;
        next_reg_en.io_ret = ret_io_en_i;
        next_reg_en.io2_ret = ret_io2_en_i;
        next_reg_en.core = 1'b0; // see (R13)
        next_ps = G_OFF;
      end
      G_OFF:
      begin
        next_reg_en.bat = 1'b0; // see (R14)
        next_reg_en.usb = 1'b0;
        next_reg_en.bandgap = 1'b0;
        next_reg_en.io = 1'b0;
        next_reg_en.io2 = 1'b0;
        next_rc_en = 1'b0;
        next_xtal_en = 1'b0;
        next_cdn = sleep_countdown_value_i;
        next_cdn_run = (sleep_countdown_value_i != '0); // see (R15)
        next_asleep = 1'b1;
        next_ps = G_SLEEP;
      end
      G_SLEEP:
      begin
        if (countdown_run_o && slk_s && !slk3)
          next_cdn = cdn - 1'b1;
        if (wake_s || (countdown_run_o && cdn == '0))
        begin
          next_asleep = 1'b0;
          next_cdn_run = 1'b0;
          next_waking = 1'b1;
          next_cnt = '0;
          next_ps = P_CMP;
        end
      end
      default:
        next_ps = P_CMP;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      ps <= P_CMP;
      waking <= 1'b0;
      cnt <= '0;
      cdn <= '0;
      reg_en_o <= '0;
      fast_rc_en_o <= 1'b0;
      fast_xtal_en_o <= 1'b0;
      clk_sel_o <= CLK_SLOW_RC; // see (R1)
      cpu_run_o <= 1'b0; // see (R23)
      addr0_map_o <= MAP_ROM;
      asleep_o <= 1'b0;
      countdown_run_o <= 1'b0;
    end
    else
    begin
      ps <= next_ps;
      waking <= next_waking;
      cnt <= next_cnt;
      cdn <= next_cdn;
      reg_en_o <= next_reg_en;
      fast_rc_en_o <= next_rc_en;
      fast_xtal_en_o <= next_xtal_en;
      clk_sel_o <= next_clk;
      cpu_run_o <= next_cpu_run;
      addr0_map_o <= next_map;
      asleep_o <= next_asleep;
      countdown_run_o <= next_cdn_run;
    end
  end

  // secded correction: flip the bit the syndrome names
  logic [OTP_W-1:0] otp_fix;
  genvar gi;
  generate
    for (gi = 0; gi < OTP_W; gi++)
    begin : g_fix
      assign otp_fix[gi] = otp_word_i[gi] ^ (otp_parity_err_i &&
        otp_syndrome_i == SYN_W'(gi + 1)); // see (R16)
    end
  endgenerate
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      otp_data_o <= '0;
      otp_corr_o <= 1'b0;
      otp_dbl_err_o <= 1'b0;
    end
    else
    begin
      otp_data_o <= otp_valid_i ? otp_fix : otp_data_o;
      otp_corr_o <= otp_valid_i && otp_parity_err_i; // see (R16)
      otp_dbl_err_o <= otp_valid_i && !otp_parity_err_i
        && otp_syndrome_i != '0;
    end
  end

  // redundant flag and inverse checks
  logic flag_ok, prod_ready, trim_ok;
  always_comb
  begin
    flag_ok = 1'b1;
    for (int i = 1; i < OTP_W / 8; i++)
      if (flag_word_i[i*8 +: 8] != flag_word_i[7:0])
        flag_ok = 1'b0; // see (R17)
  end
  assign prod_ready = flag_ok && flag_word_i[7:0] != 8'h00;
  assign trim_ok = trim_addr_word_i[OTP_W-1:HALF_W] == ~trim_addr_word_i[HALF_W-1:0]
    && trim_data_word_i[OTP_W-1:HALF_W] == ~trim_data_word_i[HALF_W-1:0]; // see (R18)

  // boot flow after a power-up release
  pws_bstate_t bs, next_bs;
  logic [2:0] tries, next_tries;
  logic [16:0] wcnt, next_wcnt;
  logic run_d;
  logic next_wr, next_retry, next_hwrst, next_xuse, next_nvm, next_ser;
  logic next_qrst, next_qinit, next_iok, next_ibad;

  always_comb
  begin
    next_bs = bs;
    next_tries = tries;
    next_wcnt = wcnt;
    next_wr = 1'b0;
    next_retry = 1'b0;
    next_hwrst = hw_reset_o;
    next_xuse = xtal_use_o;
    next_nvm = boot_nvm_o;
    next_ser = boot_serial_o;
    next_qrst = qspi_rst_o;
    next_qinit = qspi_init_o;
    next_iok = image_ok_o;
    next_ibad = image_bad_o;
    case (bs)
      B_IDLE:
        if (cpu_run_o && !run_d && addr0_map_o == MAP_ROM)
        begin
          next_tries = '0;
          next_bs = B_TRIM;
        end
      B_TRIM:
        if (trim_valid_i && !hw_reset_o)
        begin
          if (trim_ok)
          begin
            next_wr = 1'b1; // see (R18)
            if (trim_last_i)
            begin
              next_wcnt = '0;
              next_bs = B_XWAIT;
            end
          end
          else if (tries == 3'(TRIM_TRIES - 1))
            next_hwrst = 1'b1; // see (R19)
          else
          begin
            next_tries = tries + 3'h1;
            next_retry = 1'b1; // see (R19)
          end
        end
      B_XWAIT:
        if (wcnt == 17'(XTAL_WAIT - 1))
        begin
          next_xuse = 1'b1; // see (R20)
          next_bs = B_PATH;
        end
        else
          next_wcnt = wcnt + 17'h00001;
      B_PATH:
      begin
        next_nvm = prod_ready; // see (R21)
        next_ser = ~prod_ready;
        next_qrst = prod_ready && boot_qspi_i; // see (R22)
        next_bs = (prod_ready && boot_qspi_i) ? B_QRST : B_DONE;
      end
      B_QRST:
        if (qspi_done_i)
        begin
          next_qrst = 1'b0;
          next_qinit = 1'b1; // see (R22)
          next_bs = B_QINIT;
        end
      B_QINIT:
        if (qspi_done_i)
        begin
          next_qinit = 1'b0;
          next_bs = B_QMAGIC;
        end
      B_QMAGIC:
        if (magic_valid_i)
        begin
          next_iok = magic_i == QSPI_MAGIC; // see (R22)
          next_ibad = magic_i != QSPI_MAGIC;
          next_bs = B_DONE;
        end
      B_DONE:
        if (!cpu_run_o)
          next_bs = B_IDLE;
      default:
        next_bs = B_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      bs <= B_IDLE;
      tries <= '0;
      wcnt <= '0;
      run_d <= 1'b0;
      trim_wr_o <= 1'b0;
      trim_addr_o <= '0;
      trim_data_o <= '0;
      trim_retry_o <= 1'b0;
      hw_reset_o <= 1'b0;
      xtal_use_o <= 1'b0;
      boot_nvm_o <= 1'b0;
      boot_serial_o <= 1'b0;
      qspi_rst_o <= 1'b0;
      qspi_init_o <= 1'b0;
      image_ok_o <= 1'b0;
      image_bad_o <= 1'b0;
    end
    else
    begin
      bs <= next_bs;
      tries <= next_tries;
      wcnt <= next_wcnt;
      run_d <= cpu_run_o;
      trim_wr_o <= next_wr;
      trim_addr_o <= next_wr ? trim_addr_word_i[HALF_W-1:0] : trim_addr_o;
      trim_data_o <= next_wr ? trim_data_word_i[HALF_W-1:0] : trim_data_o;
      trim_retry_o <= next_retry;
      hw_reset_o <= next_hwrst;
      xtal_use_o <= next_xuse;
      boot_nvm_o <= next_nvm;
      boot_serial_o <= next_ser;
      qspi_rst_o <= next_qrst;
      qspi_init_o <= next_qinit;
      image_ok_o <= next_iok;
      image_bad_o <= next_ibad;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  property p_pwr_len;
    $rose(cpu_run_o) && !waking |-> cnt == SEQ_CNT_W'(SEQ_PWR_TICKS);
  endproperty
  a_pwr_len: assert property (p_pwr_len) else $error("power-up length"); // see (R9)
  property p_wake_len;
    $rose(cpu_run_o) && waking |-> cnt >= SEQ_CNT_W'(SEQ_WAKE_MIN);
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake too short"); // see (R10)
  property p_map;
    $rose(cpu_run_o) |-> (addr0_map_o == MAP_ROM) == !waking;
  endproperty
  a_map: assert property (p_map) else $error("address 0 map"); // see (R8)
  property p_core_order;
    $rose(reg_en_o.core) |-> reg_en_o.io && reg_en_o.io2;
  endproperty
  a_core_order: assert property (p_core_order) else $error("core early"); // see (R5)
  property p_sup_choice;
    ps == P_CMP && tick |=> reg_en_o.usb == $past(vbus_s);
  endproperty
  a_sup_choice: assert property (p_sup_choice) else $error("supply pick"); // see (R2)
  property p_sleep_seq;
    ps == P_RUN && sleep_instruction_i |=> clk_sel_o == CLK_FAST_RC
      ##1 (clk_sel_o == CLK_LOW_POWER && !reg_en_o.core)
      ##1 (asleep_o && !reg_en_o.bat && !reg_en_o.io && !reg_en_o.io2);
  endproperty
  a_sleep_seq: assert property (p_sleep_seq) else $error("sleep entry"); // see (R13)
  // the written halves must be the inverses of the upper halves offered
  property p_trim_chk;
    trim_wr_o |-> trim_addr_o == ~$past(trim_addr_word_i[OTP_W-1:HALF_W])
      && trim_data_o == ~$past(trim_data_word_i[OTP_W-1:HALF_W]);
  endproperty
  a_trim_chk: assert property (p_trim_chk) else $error("bad trim write"); // see (R18)
  property p_hwrst;
    $rose(hw_reset_o) |-> tries == 3'(TRIM_TRIES - 1);
  endproperty
  a_hwrst: assert property (p_hwrst) else $error("reset count"); // see (R19)
  property p_xwait;
    $rose(xtal_use_o) |-> $past(bs) == B_XWAIT && $past(wcnt) == 17'(XTAL_WAIT - 1);
  endproperty
  a_xwait: assert property (p_xwait) else $error("crystal wait"); // see (R20)
  c_boot: cover property ($rose(cpu_run_o) && !waking);
  c_wake: cover property ($rose(cpu_run_o) && waking);
  c_retry: cover property (trim_retry_o);
endmodule : pws_seq
